// >>> rtl/rxsof_regs.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - high register holds upper eight bits of the frame-start pattern.
// - low register holds lower eight bits of the frame-start pattern.
// - bits 7..4 give valid pattern length; software sets zero for type B.
// - bit 3 aligns grid to first falling correlation edge without a peak.
// - bit 2 makes the last frame-start bit half length.
// - type 0 treats all 16 pattern bits as raw burst; 3 reserved.
// - type 1 reads each nibble as data/collision pair; collision ignores data.
// - type 2 resynchronises on every byte start bit.
// - averaging filter combines four samples into one value.
// - squaring filter reshapes samples toward rectangular waveform.
// - grid at correlation maximum when set, minimum when clear.
// - polarity bit sets Manchester sense; zero means subcarrier first.
// - demodulator bit 1 selects frequency-shift keying.
// - demodulator bit 0 selects binary phase-shift keying when bit 1 is clear.
// - subcarrier 0 is 212 kHz, 1 is 424 kHz, 2 and 3 848 kHz.
// - clock count field picks correlation speed; value 3 reserved.
// - window bit selects 32 values when set, 64 when clear.
// - revision register is read-only, major high nibble, minor low nibble.
module rxsof_regs #(
   parameter logic [7:0] TRIM_BOOT = 8'h00,
   parameter logic [3:0] REV_MAJOR = 4'h1, // arbitrary value
   parameter logic [3:0] REV_MINOR = 4'h0  // arbitrary value
) (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // frame-start configuration
   output logic [15:0] SOF_PATTERN,
   output logic [4:0] SOF_VALID_BITS,
   output logic FIRST_FALLING_EDGE_GRID,
   output logic FINAL_SOF_BIT_HALF,
   output logic [1:0] SOF_INTERPRET_TYPE,
   // demodulator configuration
   output logic SAMPLE_AVERAGE_FILTER,
   output logic SQUARING_FILTER,
   output logic GRID_AT_PEAK,
   output logic MANCHESTER_POLARITY,
   output logic [1:0] DEMOD_SCHEME,
   // correlator configuration and receiver trim
   output logic [1:0] SUBCARRIER_SELECT,
   output logic [1:0] CORRELATION_CLOCK_COUNT,
   output logic [6:0] CORRELATION_WINDOW,
   output logic [7:0] RECEIVER_TRIM
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] sof_pattern_high;
   logic [7:0] sof_pattern_low;
   logic [7:0] sof_match_control;
   logic [7:0] demodulator_control;
   logic [7:0] correlator_control;
   logic [7:0] receiver_trim;
   logic trim_loaded;
   logic [7:0] reg_index;
   logic addr_ok;
   logic mapped;
   logic wr_en;
   logic [7:0] wdata;
   logic [7:0] next_rdata;
   logic wr_sof_high;
   logic wr_sof_low;
   logic wr_sof_ctrl;
   logic wr_demod;
   logic wr_corr;
   logic wr_trim;
   rxsof_cfg_if cfg ();

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] din,
      input logic [7:0] mask);
      merge = (old & ~mask) | (din & mask);
   endfunction

   function automatic logic reg_hit(input logic [7:0] index, input logic [7:0] target,
      input logic strobe);
      reg_hit = strobe && (index == target);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // address decode, single-cycle access
   assign reg_index = PADDR[9:2];
   assign addr_ok = (PADDR[1:0] == 2'h0) && (PADDR[31:10] == 22'h0);
   always_comb begin
      case (reg_index)
         rxsof_pkg::IDX_SOF_HIGH, rxsof_pkg::IDX_SOF_LOW, rxsof_pkg::IDX_SOF_CTRL,
         rxsof_pkg::IDX_DEMOD, rxsof_pkg::IDX_CORR, rxsof_pkg::IDX_TRIM,
         rxsof_pkg::IDX_REV: mapped = addr_ok;
         default: mapped = 1'b0;
      endcase
   end
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign wr_en = PSEL && PENABLE && PWRITE && mapped && PSTRB[0];
   assign wdata = PWDATA[7:0];
   // per-register write strobes
   assign wr_sof_high = reg_hit(reg_index, rxsof_pkg::IDX_SOF_HIGH, wr_en);
   assign wr_sof_low = reg_hit(reg_index, rxsof_pkg::IDX_SOF_LOW, wr_en);
   assign wr_sof_ctrl = reg_hit(reg_index, rxsof_pkg::IDX_SOF_CTRL, wr_en);
   assign wr_demod = reg_hit(reg_index, rxsof_pkg::IDX_DEMOD, wr_en);
   assign wr_corr = reg_hit(reg_index, rxsof_pkg::IDX_CORR, wr_en);
   assign wr_trim = reg_hit(reg_index, rxsof_pkg::IDX_TRIM, wr_en);

   ////////////////////////////////////////////////////////////////////////////
   // pattern high byte
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         sof_pattern_high <= rxsof_pkg::RST_ZERO;
      end else if (wr_sof_high) begin
         sof_pattern_high <= wdata;
      end
   end

   // pattern low byte
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         sof_pattern_low <= rxsof_pkg::RST_ZERO;
      end else if (wr_sof_low) begin
         sof_pattern_low <= wdata;
      end
   end

   // frame-start control
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         sof_match_control <= rxsof_pkg::RST_ZERO;
      end else if (wr_sof_ctrl) begin
         sof_match_control <= wdata;
      end
   end

   // demodulator control, reserved bits kept zero
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         demodulator_control <= rxsof_pkg::RST_ZERO;
      end else if (wr_demod) begin
         demodulator_control <= merge(demodulator_control, wdata,
            rxsof_pkg::MASK_DEMOD);
      end
   end

   // correlator control, reserved bits kept zero
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         correlator_control <= rxsof_pkg::RST_ZERO;
      end else if (wr_corr) begin
         correlator_control <= merge(correlator_control, wdata,
            rxsof_pkg::MASK_CORR);
      end
   end

   // trim: boot value loaded once after reset release, then writable
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         receiver_trim <= rxsof_pkg::RST_ZERO;
      end else if (!trim_loaded) begin
         receiver_trim <= TRIM_BOOT;
      end else if (wr_trim) begin
         receiver_trim <= wdata;
      end
   end

   // trim boot marker
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         trim_loaded <= 1'b0;
      end else begin
         trim_loaded <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data
   always_comb begin
      case (reg_index)
         rxsof_pkg::IDX_SOF_HIGH: next_rdata = sof_pattern_high;
         rxsof_pkg::IDX_SOF_LOW: next_rdata = sof_pattern_low;
         rxsof_pkg::IDX_SOF_CTRL: next_rdata = sof_match_control;
         rxsof_pkg::IDX_DEMOD: next_rdata = demodulator_control;
         rxsof_pkg::IDX_CORR: next_rdata = correlator_control;
         rxsof_pkg::IDX_TRIM: next_rdata = receiver_trim;
         rxsof_pkg::IDX_REV: next_rdata = {REV_MAJOR, REV_MINOR};
         default: next_rdata = rxsof_pkg::RST_ZERO;
      endcase
      if (!mapped) begin
         next_rdata = rxsof_pkg::RST_ZERO;
      end
   end
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         PRDATA <= 32'h0;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         PRDATA <= {24'h0, next_rdata};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field decode
   assign cfg.sof_match_control = sof_match_control;
   assign cfg.demodulator_control = demodulator_control;
   assign cfg.correlator_control = correlator_control;
   rxsof_decode u_decode (
      .cfg(cfg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // configuration outputs
   // pattern word
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         SOF_PATTERN <= 16'h0;
      end else begin
         SOF_PATTERN <= {sof_pattern_high, sof_pattern_low};
      end
   end

   // valid pattern length
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         SOF_VALID_BITS <= 5'h0;
      end else begin
         SOF_VALID_BITS <= cfg.sof_bits;
      end
   end

   // grid on first falling edge
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         FIRST_FALLING_EDGE_GRID <= 1'b0;
      end else begin
         FIRST_FALLING_EDGE_GRID <= sof_match_control[rxsof_pkg::SOF_FALL_BIT];
      end
   end

   // half-length final bit
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         FINAL_SOF_BIT_HALF <= 1'b0;
      end else begin
         FINAL_SOF_BIT_HALF <= sof_match_control[rxsof_pkg::SOF_HALF_BIT];
      end
   end

   // pattern interpretation
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         SOF_INTERPRET_TYPE <= 2'h0;
      end else begin
         SOF_INTERPRET_TYPE <= cfg.sync_kind;
      end
   end

   // averaging filter
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         SAMPLE_AVERAGE_FILTER <= 1'b0;
      end else begin
         SAMPLE_AVERAGE_FILTER <= demodulator_control[rxsof_pkg::DM_AVG_BIT];
      end
   end

   // squaring filter
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         SQUARING_FILTER <= 1'b0;
      end else begin
         SQUARING_FILTER <= demodulator_control[rxsof_pkg::DM_SQ_BIT];
      end
   end

   // grid position
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         GRID_AT_PEAK <= 1'b0;
      end else begin
         GRID_AT_PEAK <= demodulator_control[rxsof_pkg::DM_PEAK_BIT];
      end
   end

   // manchester sense
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         MANCHESTER_POLARITY <= 1'b0;
      end else begin
         MANCHESTER_POLARITY <= demodulator_control[rxsof_pkg::DM_POL_BIT];
      end
   end

   // demodulation scheme
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         DEMOD_SCHEME <= 2'h0;
      end else begin
         DEMOD_SCHEME <= cfg.scheme;
      end
   end

   // subcarrier choice
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         SUBCARRIER_SELECT <= 2'h0;
      end else begin
         SUBCARRIER_SELECT <= cfg.subcarrier;
      end
   end

   // correlation speed
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         CORRELATION_CLOCK_COUNT <= 2'h0;
      end else begin
         CORRELATION_CLOCK_COUNT <= correlator_control[rxsof_pkg::CR_SPEED_LSB +: 2];
      end
   end

   // correlation window
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         CORRELATION_WINDOW <= rxsof_pkg::WIN_LONG;
      end else begin
         CORRELATION_WINDOW <= cfg.window_len;
      end
   end

   // trim copy
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         RECEIVER_TRIM <= rxsof_pkg::RST_ZERO;
      end else begin
         RECEIVER_TRIM <= receiver_trim;
      end
   end
endmodule

// >>> common/rxsof_pkg.sv
package rxsof_pkg;
   // register indices (byte address is four times the index)
   localparam logic [7:0] IDX_SOF_HIGH = 8'h5a;
   localparam logic [7:0] IDX_SOF_LOW = 8'h5b;
   localparam logic [7:0] IDX_SOF_CTRL = 8'h5c;
   localparam logic [7:0] IDX_DEMOD = 8'h5d;
   localparam logic [7:0] IDX_CORR = 8'h5e;
   localparam logic [7:0] IDX_TRIM = 8'h5f;
   localparam logic [7:0] IDX_REV = 8'h7f;
   // writable bit masks, reserved bits stay zero
   localparam logic [7:0] MASK_FULL = 8'hff;
   localparam logic [7:0] MASK_DEMOD = 8'h3f;
   localparam logic [7:0] MASK_CORR = 8'hf8;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   // field positions
   localparam int SOF_LEN_LSB = 4;
   localparam int SOF_FALL_BIT = 3;
   localparam int SOF_HALF_BIT = 2;
   localparam int SOF_TYPE_LSB = 0;
   localparam int DM_AVG_BIT = 5;
   localparam int DM_SQ_BIT = 4;
   localparam int DM_PEAK_BIT = 3;
   localparam int DM_POL_BIT = 2;
   localparam int DM_FSK_BIT = 1;
   localparam int DM_BPSK_BIT = 0;
   localparam int CR_FREQ_LSB = 6;
   localparam int CR_SPEED_LSB = 4;
   localparam int CR_LEN_BIT = 3;
   localparam int REV_MAJOR_LSB = 4;
   // enumerations
   typedef enum logic [1:0] {
      RXSOF_SYNC_BURST, RXSOF_SYNC_PAIR, RXSOF_SYNC_BYTE, RXSOF_SYNC_RSVD
   } rxsof_sync_t;
   typedef enum logic [1:0] {
      RXSOF_SC_212, RXSOF_SC_424, RXSOF_SC_848
   } rxsof_subcarrier_t;
   typedef enum logic [1:0] {
      RXSOF_DEMOD_SUBC, RXSOF_DEMOD_FSK, RXSOF_DEMOD_BPSK
   } rxsof_scheme_t;
   localparam logic [6:0] WIN_SHORT = 7'h20;
   localparam logic [6:0] WIN_LONG = 7'h40;
   localparam logic [4:0] SOF_FULL_BITS = 5'h10;
endpackage

// >>> common/rxsof_cfg_if.sv
`timescale 1ns/100ps
interface rxsof_cfg_if;
   logic [7:0] sof_match_control;
   logic [7:0] demodulator_control;
   logic [7:0] correlator_control;
   logic [4:0] sof_bits;
   rxsof_pkg::rxsof_sync_t sync_kind;
   rxsof_pkg::rxsof_subcarrier_t subcarrier;
   rxsof_pkg::rxsof_scheme_t scheme;
   logic [6:0] window_len;
   modport regs (output sof_match_control, demodulator_control, correlator_control,
      input sof_bits, sync_kind, subcarrier, scheme, window_len);
   modport dec (input sof_match_control, demodulator_control, correlator_control,
      output sof_bits, sync_kind, subcarrier, scheme, window_len);
endinterface

// >>> rtl/rxsof_decode.sv
`timescale 1ns/100ps
module rxsof_decode (
   rxsof_cfg_if.dec cfg
);
   logic [1:0] sync_field;
   logic [1:0] freq_field;
   assign sync_field = cfg.sof_match_control[rxsof_pkg::SOF_TYPE_LSB +: 2];
   assign freq_field = cfg.correlator_control[rxsof_pkg::CR_FREQ_LSB +: 2];
   // zero length means the whole pattern is used
   assign cfg.sof_bits = (cfg.sof_match_control[rxsof_pkg::SOF_LEN_LSB +: 4] == 4'h0) ?
      rxsof_pkg::SOF_FULL_BITS : {1'b0, cfg.sof_match_control[rxsof_pkg::SOF_LEN_LSB +: 4]};
   assign cfg.sync_kind = rxsof_pkg::rxsof_sync_t'(sync_field);
   always_comb begin
      case (freq_field)
         2'h0: cfg.subcarrier = rxsof_pkg::RXSOF_SC_212;
         2'h1: cfg.subcarrier = rxsof_pkg::RXSOF_SC_424;
         default: cfg.subcarrier = rxsof_pkg::RXSOF_SC_848;
      endcase
   end
   always_comb begin
      if (cfg.demodulator_control[rxsof_pkg::DM_FSK_BIT]) begin
         cfg.scheme = rxsof_pkg::RXSOF_DEMOD_FSK;
      end else if (cfg.demodulator_control[rxsof_pkg::DM_BPSK_BIT]) begin
         cfg.scheme = rxsof_pkg::RXSOF_DEMOD_BPSK;
      end else begin
         cfg.scheme = rxsof_pkg::RXSOF_DEMOD_SUBC;
      end
   end
   assign cfg.window_len = cfg.correlator_control[rxsof_pkg::CR_LEN_BIT] ?
      rxsof_pkg::WIN_SHORT : rxsof_pkg::WIN_LONG;
endmodule

// >>> verif/rxsof_regs_chk.sv
`timescale 1ns/100ps
module rxsof_regs_chk #(
   parameter logic [3:0] REV_MAJOR = 4'h1,
   parameter logic [3:0] REV_MINOR = 4'h0
) (
   // clock, reset and apb
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // configuration outputs
   input wire logic [15:0] SOF_PATTERN,
   input wire logic [4:0] SOF_VALID_BITS,
   input wire logic FIRST_FALLING_EDGE_GRID,
   input wire logic FINAL_SOF_BIT_HALF,
   input wire logic [1:0] SOF_INTERPRET_TYPE,
   input wire logic SAMPLE_AVERAGE_FILTER,
   input wire logic SQUARING_FILTER,
   input wire logic GRID_AT_PEAK,
   input wire logic MANCHESTER_POLARITY,
   input wire logic [1:0] DEMOD_SCHEME,
   input wire logic [1:0] SUBCARRIER_SELECT,
   input wire logic [1:0] CORRELATION_CLOCK_COUNT,
   input wire logic [6:0] CORRELATION_WINDOW
);
   logic wr;
   logic rd;
   logic [7:0] d1;
   logic [7:0] d2;
   assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];
   assign rd = PSEL && PENABLE && !PWRITE;
   // write data two cycles back, when the outputs show it
   always_ff @(posedge CLK_SYS) begin
      d1 <= PWDATA[7:0];
      d2 <= d1;
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);
   property p_high; wr && PADDR == 32'h168 |-> ##2 SOF_PATTERN[15:8] == d2; endproperty
   a_high: assert property (p_high) else $error("pattern high mismatch");
   property p_low; wr && PADDR == 32'h16c |-> ##2 SOF_PATTERN[7:0] == d2; endproperty
   a_low: assert property (p_low) else $error("pattern low mismatch");
   property p_ctl; wr && PADDR == 32'h170 |-> ##2
      {FIRST_FALLING_EDGE_GRID, FINAL_SOF_BIT_HALF, SOF_INTERPRET_TYPE} == d2[3:0]; endproperty
   a_ctl: assert property (p_ctl) else $error("frame start bits mismatch");
   property p_len; wr && PADDR == 32'h170 |-> ##2
      SOF_VALID_BITS == (d2[7:4] == 4'h0 ? 5'h10 : {1'b0, d2[7:4]}); endproperty
   a_len: assert property (p_len) else $error("valid length mismatch");
   property p_filt; wr && PADDR == 32'h174 |-> ##2 {SAMPLE_AVERAGE_FILTER, SQUARING_FILTER,
      GRID_AT_PEAK, MANCHESTER_POLARITY} == d2[5:2]; endproperty
   a_filt: assert property (p_filt) else $error("filter bits mismatch");
   property p_sch; wr && PADDR == 32'h174 |-> ##2
      DEMOD_SCHEME == (d2[1] ? 2'h1 : {d2[0], 1'b0}); endproperty
   a_sch: assert property (p_sch) else $error("scheme mismatch");
   property p_corr; wr && PADDR == 32'h178 |-> ##2 CORRELATION_CLOCK_COUNT == d2[5:4] &&
      SUBCARRIER_SELECT == (d2[7] ? 2'h2 : {1'b0, d2[6]}); endproperty
   a_corr: assert property (p_corr) else $error("correlator mismatch");
   property p_win; wr && PADDR == 32'h178 |-> ##2
      CORRELATION_WINDOW == (d2[3] ? 7'h20 : 7'h40); endproperty
   a_win: assert property (p_win) else $error("window mismatch");
   property p_rev; rd && PADDR == 32'h1fc |-> PRDATA == {24'h0, REV_MAJOR, REV_MINOR}; endproperty
   a_rev: assert property (p_rev) else $error("revision mismatch");
   property p_ready; PSEL && PENABLE && PADDR == 32'h1fc |-> PREADY && !PSLVERR; endproperty
   a_ready: assert property (p_ready) else $error("mapped access answer wrong");
   property p_refuse; PSEL && PENABLE && PADDR == 32'h180 |-> PREADY && PSLVERR; endproperty
   a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
endmodule
bind rxsof_regs rxsof_regs_chk #(.REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR)) chk_u (.*);

// >>> verif/test_rx_sof_correlator_config.sv
`timescale 1ns/100ps
module test_rx_sof_correlator_config;
   logic CLK_SYS = 1'b0;
   logic ARST_N = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [31:0] PADDR = 32'h0;
   logic [31:0] PWDATA = 32'h0;
   logic [3:0] PSTRB = 4'h0;
   logic [31:0] PRDATA, q;
   logic PREADY, PSLVERR, e, FIRST_FALLING_EDGE_GRID, FINAL_SOF_BIT_HALF;
   logic SAMPLE_AVERAGE_FILTER, SQUARING_FILTER, GRID_AT_PEAK, MANCHESTER_POLARITY;
   logic [15:0] SOF_PATTERN;
   logic [4:0] SOF_VALID_BITS;
   logic [1:0] SOF_INTERPRET_TYPE, DEMOD_SCHEME, SUBCARRIER_SELECT, CORRELATION_CLOCK_COUNT;
   logic [6:0] CORRELATION_WINDOW;
   logic [7:0] RECEIVER_TRIM;
   int fail_count = 0;
   int checks_done = 0;
   rxsof_regs #(.TRIM_BOOT(8'h5c), .REV_MAJOR(4'h2), .REV_MINOR(4'h7)) dut_u (.*);
   always #20 CLK_SYS = ~CLK_SYS;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (fail_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checks_done++;
      if (g !== x) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // one apb transfer, result left in q and e
   task automatic xfer(input logic [31:0] a, input logic w, input logic [3:0] s,
         input logic [7:0] d);
      int n;
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= {24'h0, d};
      PSTRB <= s;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (PREADY !== 1'b1 && n < 16);
      if (n >= 16) begin
         chk(32'h1, 32'h0);
         report_and_stop();
      end
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr_rd(input logic [31:0] a, input logic [7:0] d, input logic [7:0] x);
      xfer(a, 1'b1, 4'hf, d);
      xfer(a, 1'b0, 4'hf, 8'h00);
      chk(q, {24'h0, x});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         xfer(32'h168 + 4 * i, 1'b0, 4'hf, 8'h00);
         chk(q, i == 5 ? 32'h5c : 32'h0);
      end
      chk(32'(SOF_VALID_BITS), 32'h10);
      chk(32'(CORRELATION_WINDOW), 32'h40);
      chk(32'(RECEIVER_TRIM), 32'h5c);
   endtask
   task automatic t_pattern;
      wr_rd(32'h168, 8'ha5, 8'ha5);
      wr_rd(32'h16c, 8'h3c, 8'h3c);
      xfer(32'h16c, 1'b1, 4'he, 8'hff);
      xfer(32'h16c, 1'b0, 4'hf, 8'h00);
      chk(q, 32'h3c);
      chk(32'(SOF_PATTERN), 32'ha53c);
   endtask
   task automatic t_sofctl;
      logic [7:0] v [4] = '{8'h00, 8'h59, 8'h06, 8'hff};
      for (int i = 0; i < 4; i++) begin
         wr_rd(32'h170, v[i], v[i]);
         chk(32'(SOF_VALID_BITS), v[i][7:4] == 4'h0 ? 32'h10 : 32'(v[i][7:4]));
         chk(32'({FIRST_FALLING_EDGE_GRID, FINAL_SOF_BIT_HALF, SOF_INTERPRET_TYPE}),
            32'(v[i][3:0]));
      end
   endtask
   task automatic t_demod;
      logic [7:0] v [4] = '{8'hff, 8'h01, 8'h00, 8'h55};
      logic [1:0] s [4] = '{2'h1, 2'h2, 2'h0, 2'h2};
      for (int i = 0; i < 4; i++) begin
         wr_rd(32'h174, v[i], v[i] & 8'h3f);
         chk(32'({SAMPLE_AVERAGE_FILTER, SQUARING_FILTER, GRID_AT_PEAK, MANCHESTER_POLARITY}),
            32'(v[i][5:2]));
         chk(32'(DEMOD_SCHEME), 32'(s[i]));
      end
   endtask
   task automatic t_corr;
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {2'(i), 2'(i), 1'(i), 3'h7};
         wr_rd(32'h178, v, v & 8'hf8);
         chk(32'(SUBCARRIER_SELECT), i > 1 ? 32'h2 : 32'(i));
         chk(32'(CORRELATION_CLOCK_COUNT), 32'(i));
         chk(32'(CORRELATION_WINDOW), i[0] ? 32'h20 : 32'h40);
      end
   endtask
   task automatic t_misc;
      wr_rd(32'h1fc, 8'hff, 8'h27);
      chk(32'(e), 32'h0);
      xfer(32'h17c, 1'b0, 4'hf, 8'h00);
      chk(q, 32'h5c);
      chk(32'(RECEIVER_TRIM), 32'h5c);
      wr_rd(32'h180, 8'hff, 8'h00);
      chk(32'(e), 32'h1);
      xfer(32'h169, 1'b0, 4'hf, 8'h00);
      chk(32'(e), 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge CLK_SYS);
      ARST_N <= 1'b1;
      t_reset();
      t_pattern();
      t_sofctl();
      t_demod();
      t_corr();
      t_misc();
      report_and_stop();
   end
endmodule
